// ==== hw/ebt_pkg.sv ====
// Package for the eight-bit timer control block: register map, field
// positions, reset values and prescaler counts.
// Assumes an APB master with 32-bit data; each register is one aligned word.
package ebt_pkg;

  // ****************************************************************
  // Register indices and byte offsets
  // ****************************************************************
  // Printed offsets 3C..44 are not all multiples of four, so they are
  // indices and the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL_B = 8'h3C; // Control two.
  localparam logic [7:0] IDX_CTRL_A = 8'h3D; // Control one.
  localparam logic [7:0] IDX_STATUS = 8'h3E; // Flags and freeze.
  localparam logic [7:0] IDX_CAP_A = 8'h3F; // Capture value A.
  localparam logic [7:0] IDX_CMP_A = 8'h40; // Compare value A.
  localparam logic [7:0] IDX_CNT = 8'h41; // Main counter.
  localparam logic [7:0] IDX_ALT_CNT = 8'h42; // Alternate counter.
  localparam logic [7:0] IDX_CAP_B = 8'h43; // Capture value B.
  localparam logic [7:0] IDX_CMP_B = 8'h44; // Compare value B.
  localparam int ADDR_W = 10; // Byte address bits decoded.

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int A_CAP_IE = 7;
  localparam int A_CMP_IE = 6;
  localparam int A_OVF_IE = 5;
  localparam int A_FORCE_B = 4;
  localparam int A_FORCE_A = 3;
  localparam int A_LEVEL_B = 2;
  localparam int A_EDGE_A = 1;
  localparam int A_LEVEL_A = 0;
  localparam int B_PIN_A_EN = 7;
  localparam int B_PIN_B_EN = 6;
  localparam int B_ONE_PULSE = 5;
  localparam int B_PWM = 4;
  localparam int B_CLK_HI = 3;
  localparam int B_CLK_LO = 2;
  localparam int B_EDGE_B = 1;
  localparam int S_CAP_A = 7;
  localparam int S_CMP_A = 6;
  localparam int S_OVF = 5;
  localparam int S_CAP_B = 4;
  localparam int S_CMP_B = 3;
  localparam int S_FREEZE = 2;

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_WMASK = 8'hFE; // Bit 0 is reserved.
  localparam logic [7:0] CNT_RESET = 8'hFC; // Counter start and reload.
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [7:0] ONE_PULSE_CAP = 8'hFD; // Captured on a trigger.
  localparam logic [13:0] DIV_BY2 = 14'h0002;
  localparam logic [13:0] DIV_BY4 = 14'h0004;
  localparam logic [13:0] DIV_BY8 = 14'h0008;
  localparam logic [13:0] DIV_SLOW = 14'h1F40; // 8000.

  // Clock select codes.
  typedef enum logic [1:0] {
    EBT_CLK_DIV4 = 2'b00,
    EBT_CLK_DIV2 = 2'b01,
    EBT_CLK_DIV8 = 2'b10,
    EBT_CLK_SLOW = 2'b11
  } ebt_clk_sel_t;

  // Pin group to the outside.
  typedef struct packed {
    logic out_a; // Compare output A level.
    logic oe_a; // Timer owns pin A.
    logic out_b; // Compare output B level.
    logic oe_b; // Timer owns pin B.
  } ebt_pins_t;

endpackage : ebt_pkg

// ==== hw/ebt_timer.sv ====
// Eight-bit free-running timer with two captures, two compares, one-pulse
// and PWM modes, and an APB register port.
// Assumes pclk is the CPU clock; capture pins and osc_div_tick are async.
//
// Overview of operation
// - one shared request, enable and unmasked
// - all events wake from wait, not halt
// - capture enable gates capture flag requests
// - compare enable gates compare flag requests
// - overflow enable gates overflow flag request
// - force B copies level_b to pin B
// - force A copies level_a to pin A
// - compare B match copies level_b out
// - edge_sel_a picks capture A edge
// - compare A match copies level_a out
// - pin enables route levels only
// - one-pulse: capture A edge starts pulse
// - PWM: width from A, period from B
// - clock_select picks divide four/two/eight/8000
// - edge_sel_b picks capture B edge
// - capture flag A set and cleared
// - compare flag A set and cleared
// - overflow flag; alternate counter keeps it
// - capture flag B set and cleared
// - compare flag B set and cleared
// - freeze stops count and outputs
// - both modes selected runs PWM only
// - PWM compare B reloads counter FCh
// - status read must see flag set
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module ebt_timer
  import ebt_pkg::*;
#(
  parameter int SLOW_DIV = 8000 // Slow prescale ratio, shorten in sim.
) (
  input wire logic pclk, // CPU clock, 25 MHz.
  input wire logic presetn, // Async reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [ebt_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error on unmapped address.
  input wire logic irq_mask, // CPU interrupt mask, high masks.
  input wire logic halt_mode, // Device in halt.
  input wire logic osc_div_tick, // Oscillator-derived slow tick level.
  input wire logic capture_in_a, // Capture pin A.
  input wire logic capture_in_b, // Capture pin B.
  output ebt_pkg::ebt_pins_t pins, // Compare pins with enables.
  output logic timer_irq, // Shared interrupt request.
  output logic wake_req // Wake request from wait mode.
);
  import ebt_pkg::*;

  initial begin
    if (SLOW_DIV < 2 || SLOW_DIV > 16383) begin
      $error("SLOW_DIV out of range");
    end
  end

  // ****************************************************************
  // Registers and bus decode
  // ****************************************************************
  logic [7:0] ctrl_a; // Control one.
  logic [7:0] ctrl_b; // Control two.
  logic [7:0] flags; // Status flags, bits 7..3.
  logic freeze; // Timer freeze bit.
  logic [7:0] cnt; // Counter.
  logic [7:0] cap_a; // Capture value A.
  logic [7:0] cap_b; // Capture value B.
  logic [7:0] cmp_a; // Compare A, software copy.
  logic [7:0] cmp_b; // Compare B, software copy.
  logic [7:0] act_a; // Compare A in use.
  logic [7:0] act_b; // Compare B in use.
  logic [7:0] armed; // Flags seen set by a status read.
  logic out_a; // Output A level.
  logic out_b; // Output B level.
  logic access; // APB access phase this cycle.
  logic [7:0] idx; // Register index.
  logic hit; // Address maps to a register.

  // Decodes the word index from a byte address.
  function automatic logic [7:0] word_index(
    input logic [ADDR_W-1:0] addr
  );
    word_index = addr[ADDR_W-1:2];
  endfunction : word_index

  assign access = psel && penable;
  assign idx = word_index(paddr);
  assign hit = (idx >= IDX_CTRL_B) && (idx <= IDX_CMP_B) &&
               (paddr[1:0] == 2'b00);
  // Zero-wait slave keeps the bus simple; every access takes two cycles.
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  // reserved bits dropped
  // Control writes; reserved bit 0 of control two is never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a <= CTRL_RESET;
      ctrl_b <= CTRL_RESET;
      freeze <= 1'b0;
      cmp_a <= CTRL_RESET;
      cmp_b <= CTRL_RESET;
    end else if (access && pwrite) begin
      if (idx == IDX_CTRL_A) begin
        ctrl_a <= pwdata[7:0];
      end
      if (idx == IDX_CTRL_B) begin
        ctrl_b <= pwdata[7:0] & CTRL_B_WMASK;
      end
      if (idx == IDX_STATUS) begin
        freeze <= pwdata[S_FREEZE];
      end
      if (idx == IDX_CMP_A) begin
        cmp_a <= pwdata[7:0];
      end
      if (idx == IDX_CMP_B) begin
        cmp_b <= pwdata[7:0];
      end
    end
  end

  // Read mux; data is registered so prdata comes from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (idx)
        IDX_CTRL_B: prdata <= {24'h000000, ctrl_b};
        IDX_CTRL_A: prdata <= {24'h000000, ctrl_a};
        IDX_STATUS: prdata <= {24'h000000, flags[7:3], freeze, 2'b00};
        IDX_CAP_A: prdata <= {24'h000000, cap_a};
        IDX_CMP_A: prdata <= {24'h000000, cmp_a};
        IDX_CNT, IDX_ALT_CNT: prdata <= {24'h000000, cnt};
        IDX_CAP_B: prdata <= {24'h000000, cap_b};
        IDX_CMP_B: prdata <= {24'h000000, cmp_b};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] sync_a; // Capture A sync, bit 0 is first stage.
  logic [2:0] sync_b; // Capture B sync.
  logic [2:0] sync_t; // Slow tick sync.

  // Bit 0 feeds only bit 1; edges are taken between bits 1 and 2.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_t <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], capture_in_a};
      sync_b <= {sync_b[1:0], capture_in_b};
      sync_t <= {sync_t[1:0], osc_div_tick};
    end
  end

  // Picks the selected edge between the old and new synced levels.
  function automatic logic edge_hit(
    input logic rising,
    input logic old_lvl,
    input logic new_lvl
  );
    edge_hit = rising ? (new_lvl && !old_lvl) : (!new_lvl && old_lvl);
  endfunction : edge_hit

  logic pwm_on; // PWM active.
  logic pulse_on; // One-pulse active.
  logic cap_ev_a; // Capture A edge.
  logic cap_ev_b; // Capture B edge.

  assign pwm_on = ctrl_b[B_PWM];
  assign pulse_on = ctrl_b[B_ONE_PULSE] && !pwm_on;
  assign cap_ev_a = edge_hit(ctrl_a[A_EDGE_A], sync_a[2], sync_a[1]);
  assign cap_ev_b = edge_hit(ctrl_b[B_EDGE_B], sync_b[2], sync_b[1]);

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [13:0] pre_cnt; // Prescale counter.
  logic [13:0] div_n; // Selected ratio.
  logic tick; // Counter advance.
  logic slow_sel; // Slow clock chosen.

  always_comb begin
    slow_sel = 1'b0;
    unique case (ebt_clk_sel_t'(ctrl_b[B_CLK_HI:B_CLK_LO]))
      EBT_CLK_DIV4: div_n = DIV_BY4;
      EBT_CLK_DIV2: div_n = DIV_BY2;
      EBT_CLK_DIV8: div_n = DIV_BY8;
      EBT_CLK_SLOW: begin
        div_n = 14'(SLOW_DIV);
        slow_sel = 1'b1;
      end
    endcase
  end

  // Slow mode counts oscillator ticks; others count CPU clocks.
  assign tick = !freeze && (pre_cnt == div_n - 14'h0001) &&
                (!slow_sel || (sync_t[1] && !sync_t[2]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 14'h0000;
    end else if (freeze) begin
      pre_cnt <= pre_cnt;
    end else if (tick || pre_cnt >= div_n) begin
      pre_cnt <= 14'h0000;
    end else if (!slow_sel || (sync_t[1] && !sync_t[2])) begin
      pre_cnt <= pre_cnt + 14'h0001;
    end
  end

  // ****************************************************************
  // Counter, captures and compares
  // ****************************************************************
  logic match_a; // Counter meets compare A.
  logic match_b; // Counter meets compare B.
  logic cnt_wr; // Software counter reset.
  logic trig; // One-pulse trigger.

  assign match_a = tick && (cnt == act_a);
  assign match_b = tick && (cnt == act_b);
  assign cnt_wr = access && pwrite &&
                  (idx == IDX_CNT || idx == IDX_ALT_CNT);
  assign trig = pulse_on && cap_ev_a && !freeze;

  // Counter: software write resets, PWM period and pulse trigger reload.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= CNT_RESET;
    end else if (cnt_wr || trig) begin
      cnt <= CNT_RESET;
    end else if (pwm_on && match_b) begin
      cnt <= CNT_RESET;
    end else if (tick) begin
      cnt <= cnt + 8'h01;
    end
  end

  // PWM double buffer; new values apply at period end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_a <= CTRL_RESET;
      act_b <= CTRL_RESET;
    end else if (!pwm_on || match_b) begin
      act_a <= cmp_a;
      act_b <= cmp_b;
    end
  end

  // Capture registers; one-pulse uses pin A as trigger, not capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_a <= CTRL_RESET;
      cap_b <= CTRL_RESET;
    end else begin
      if (trig) begin
        cap_a <= ONE_PULSE_CAP;
      end else if (cap_ev_a && !pwm_on) begin
        cap_a <= cnt;
      end
      if (cap_ev_b) begin
        cap_b <= cnt;
      end
    end
  end

  // ****************************************************************
  // Flags and clear sequence
  // ****************************************************************
  logic [7:0] set_ev; // Flag set events this cycle.
  logic [7:0] clr_ev; // Flag clear requests this cycle.
  logic stat_rd; // Status register read.

  always_comb begin
    set_ev = 8'h00;
    set_ev[S_CAP_A] = pwm_on ? match_b : (cap_ev_a && (!pulse_on || trig));
    // compare flag A, not in pulse or PWM
    set_ev[S_CMP_A] = match_a && !pwm_on && !pulse_on;
    set_ev[S_OVF] = tick && (cnt == CNT_TOP) && !cnt_wr;
    set_ev[S_CAP_B] = cap_ev_b;
    set_ev[S_CMP_B] = match_b && !pwm_on;
  end

  assign stat_rd = access && !pwrite && (idx == IDX_STATUS);

  always_comb begin
    clr_ev = 8'h00;
    if (access && !(idx == IDX_STATUS)) begin
      clr_ev[S_CAP_A] = idx == IDX_CAP_A;
      clr_ev[S_CMP_A] = idx == IDX_CMP_A;
      clr_ev[S_OVF] = idx == IDX_CNT;
      clr_ev[S_CAP_B] = idx == IDX_CAP_B;
      clr_ev[S_CMP_B] = idx == IDX_CMP_B;
    end
    clr_ev = clr_ev & armed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 8'h00;
    end else if (stat_rd) begin
      armed <= flags;
    end else begin
      armed <= armed & ~clr_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 8'h00;
    end else begin
      flags <= (flags & ~clr_ev) | set_ev;
    end
  end

  // ****************************************************************
  // Compare outputs
  // ****************************************************************
  // Output A and B levels; forcing and matches act without the pin enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else if (!freeze) begin
      if (pwm_on || pulse_on) begin
        if ((pwm_on && match_b) || trig) begin
          out_a <= ctrl_a[A_LEVEL_B];
        end else if (match_a) begin
          out_a <= ctrl_a[A_LEVEL_A];
        end
      end else begin
        if (ctrl_a[A_FORCE_A] || match_a) begin
          out_a <= ctrl_a[A_LEVEL_A];
        end
        if (ctrl_a[A_FORCE_B] || match_b) begin
          out_b <= ctrl_a[A_LEVEL_B];
        end
      end
    end
  end

  assign pins.out_a = out_a;
  assign pins.out_b = out_b;
  assign pins.oe_a = ctrl_b[B_PIN_A_EN] && !freeze;
  assign pins.oe_b = ctrl_b[B_PIN_B_EN] && !freeze && !pwm_on && !pulse_on;

  // ****************************************************************
  // Interrupt request and wake
  // ****************************************************************
  logic irq_any; // Enabled source pending.

  assign irq_any =
    (ctrl_a[A_CAP_IE] && (flags[S_CAP_A] || flags[S_CAP_B])) ||
    (ctrl_a[A_CMP_IE] && (flags[S_CMP_A] || flags[S_CMP_B])) ||
    (ctrl_a[A_OVF_IE] && flags[S_OVF]);

  assign timer_irq = irq_any && !irq_mask;
  assign wake_req = timer_irq && !halt_mode;

endmodule : ebt_timer

`default_nettype wire

// ==== bench/ebt_pin_model.sv ====
// Model of the pins around the timer: two capture sources and a load on
// compare pin A. Assumes the bench calls set_cap from its main sequence.
`timescale 1ns/100ps
`default_nettype none
module ebt_pin_model (
  input wire logic pclk, // CPU clock.
  input wire ebt_pkg::ebt_pins_t pins, // Compare pins from the timer.
  output logic capture_in_a, // Capture source A.
  output logic capture_in_b, // Capture source B.
  output var int rise_a // Rising edges seen by the load on pin A.
);
  import ebt_pkg::*;
  logic last_a; // Level of pin A one cycle back.
  initial begin
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
    rise_a = 0;
    last_a = 1'b0;
  end
  // A source changes only just after a clock edge, like a real driver.
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 0) begin
      capture_in_a <= lvl;
    end else begin
      capture_in_b <= lvl;
    end
  endtask : set_cap
  // The load sees the pin only while the timer owns it.
  always @(posedge pclk) begin
    if (pins.oe_a && pins.out_a && !last_a) begin
      rise_a <= rise_a + 1;
    end
    last_a <= pins.oe_a && pins.out_a;
  end
endmodule : ebt_pin_model
`default_nettype wire

// ==== bench/ebt_timer_asserts.sv ====
// Checker for the timer's APB port, interrupt request and pin group.
// Assumes it is bound into ebt_timer and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ebt_timer_asserts (
  input wire logic pclk, // CPU clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [ebt_pkg::ADDR_W-1:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic irq_mask, // Interrupt mask.
  input wire logic halt_mode, // Halt state.
  input wire ebt_pkg::ebt_pins_t pins, // Compare pins.
  input wire logic timer_irq, // Interrupt request.
  input wire logic wake_req // Wake request.
);
  import ebt_pkg::*;
  // ********
  // Decode
  // ********
  logic wr; // Write taken at this edge.
  logic rd; // Read in its access phase.
  logic [7:0] idx; // Word index of the access.
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign idx = paddr[ADDR_W-1:2];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ********
  // Properties
  // ********
  a_irq_masked: assert property (irq_mask |-> !timer_irq)
    else $error("timer_irq high while masked");
  a_wake_gate: assert property (wake_req == (timer_irq && !halt_mode))
    else $error("wake_req does not follow request and halt");
  a_no_enable: assert property (wr && idx == IDX_CTRL_A
    && pwdata[7:5] == 3'b000 |=> !timer_irq)
    else $error("timer_irq high with all enables off");
  a_freeze_pins: assert property (wr && idx == IDX_STATUS
    && pwdata[S_FREEZE] |=> !pins.oe_a && !pins.oe_b)
    else $error("pins still driven while frozen");
  a_pin_a_off: assert property (wr && idx == IDX_CTRL_B
    && !pwdata[B_PIN_A_EN] |=> !pins.oe_a)
    else $error("pin A driven with its enable off");
  a_pin_b_mode: assert property (wr && idx == IDX_CTRL_B
    && (pwdata[B_PWM] || pwdata[B_ONE_PULSE]) |=> !pins.oe_b)
    else $error("pin B driven in pulse modes");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped: assert property (psel && penable && (paddr[1:0] != 2'b00
    || idx < IDX_CTRL_B || idx > IDX_CMP_B)
    |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
  a_rsvd_ctrl: assert property (rd && idx == IDX_CTRL_B
    |-> prdata[0] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("reserved control bits read nonzero");
  a_rsvd_status: assert property (rd && idx == IDX_STATUS
    |-> prdata[1:0] == 2'b00)
    else $error("reserved status bits read nonzero");
endmodule : ebt_timer_asserts
bind ebt_timer ebt_timer_asserts u_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_mask(irq_mask), .halt_mode(halt_mode), .pins(pins),
  .timer_irq(timer_irq), .wake_req(wake_req));
`default_nettype wire

// ==== bench/eight_bit_timer_control_test.sv ====
// Self-checking bench for ebt_timer: APB tasks and register sequences.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module eight_bit_timer_control_test;
  import ebt_pkg::*;
  logic pclk = 1'b0; // CPU clock.
  logic presetn = 1'b0; // Reset, active low.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB access phase.
  logic pwrite = 1'b0; // APB direction.
  logic [ADDR_W-1:0] paddr = '0; // APB address.
  logic [31:0] pwdata = '0; // APB write data.
  logic [31:0] prdata; // APB read data.
  logic pready; // APB ready.
  logic pslverr; // APB error.
  logic irq_mask = 1'b0; // Interrupt mask.
  logic halt_mode = 1'b0; // Halt state.
  logic osc_div_tick = 1'b0; // Slow reference.
  logic capture_in_a; // Capture pin A.
  logic capture_in_b; // Capture pin B.
  ebt_pins_t pins; // Compare pins.
  logic timer_irq; // Interrupt request.
  logic wake_req; // Wake request.
  int err_count = 0; // Mismatches.
  int checked = 0; // Comparisons.
  int cyc = 0; // Cycles run, for the timeout.
  int rise_a; // Pulses seen by the load.
  int r0; // Pulse count at a start point.
  logic [31:0] rdv; // Last read data.
  logic err_seen; // Last pslverr.
  logic [7:0] v0; // Scratch counter value.
  logic [7:0] v1; // Scratch counter delta.
  logic [7:0] rate [4] = '{8'h0C, 8'h18, 8'h06, 8'h06}; // Counts in 48.
  always #20 pclk = ~pclk;
  // The slow reference toggles on falling edges only, so never races.
  always #40 osc_div_tick = ~osc_div_tick;
  ebt_timer #(.SLOW_DIV(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_mask(irq_mask), .halt_mode(halt_mode),
    .osc_div_tick(osc_div_tick), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .pins(pins), .timer_irq(timer_irq),
    .wake_req(wake_req));
  ebt_pin_model u_pins (.pclk(pclk), .pins(pins),
    .capture_in_a(capture_in_a), .capture_in_b(capture_in_b),
    .rise_a(rise_a));
  // ********
  // Tasks
  // ********
  task automatic test_done();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs are looked at mid-cycle, once this edge's updates settle.
    @(negedge pclk);
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] idx,
                      input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, idx, 8'h00);
    chk(n, e & m, rdv & m);
  endtask : rchk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  // Flag clearing needs the status read first, then the data register.
  task automatic clr(input logic [7:0] idx);
    apb(1'b0, IDX_STATUS, 8'h00);
    apb(1'b0, idx, 8'h00);
  endtask : clr
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    logic [7:0] ci;
    logic [7:0] fb;
    logic [7:0] md [2];
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl_a", IDX_CTRL_A, 32'h0, 32'hFF);
    rchk("ctrl_b", IDX_CTRL_B, 32'h0, 32'hFF);
    rchk("status", IDX_STATUS, 32'h0, 32'h07);
    rchk("cmp_a", IDX_CMP_A, 32'h0, 32'hFF);
    rchk("cmp_b", IDX_CMP_B, 32'h0, 32'hFF);
    wr(IDX_CTRL_B, 8'hFE);
    rchk("ctrl_b rw", IDX_CTRL_B, 32'hFE, 32'hFFFFFFFF);
    wr(IDX_STATUS, 8'hFC);
    rchk("freeze bit", IDX_STATUS, 32'h04, 32'h07);
    apb(1'b0, 8'hFF, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err_seen});
    chk("unmapped data", 32'h0, rdv);
    apb(1'b0, IDX_CNT, 8'h00);
    v0 = rdv[7:0];
    repeat (20) @(posedge pclk);
    rchk("frozen count", IDX_CNT, {24'h0, v0}, 32'hFF);
    wr(IDX_STATUS, 8'h00);
    // Overflow and both compares at zero, pin A enabled, divide by two.
    wr(IDX_CTRL_B, 8'h84);
    wr(IDX_CTRL_A, 8'h21);
    wr(IDX_CNT, 8'h00);
    repeat (30) @(posedge pclk);
    rchk("flags set", IDX_STATUS, 32'h68, 32'h68);
    chk("ovf irq", 32'h1, {31'h0, timer_irq});
    chk("match out_a", 32'h1, {31'h0, pins.out_a});
    chk("pin a owned", 32'h1, {31'h0, pins.oe_a});
    wr(IDX_CTRL_A, 8'h41);
    chk("cmp irq", 32'h1, {31'h0, timer_irq});
    wr(IDX_CTRL_A, 8'h21);
    @(posedge pclk);
    irq_mask <= 1'b1;
    @(negedge pclk);
    chk("masked irq", 32'h0, {31'h0, timer_irq});
    @(posedge pclk);
    irq_mask <= 1'b0;
    halt_mode <= 1'b1;
    @(negedge pclk);
    chk("halt wake", 32'h0, {31'h0, wake_req});
    @(posedge pclk);
    halt_mode <= 1'b0;
    @(negedge pclk);
    chk("wait wake", 32'h1, {31'h0, wake_req});
    clr(IDX_ALT_CNT);
    rchk("ovf kept", IDX_STATUS, 32'h20, 32'h20);
    apb(1'b0, IDX_CNT, 8'h00);
    rchk("ovf cleared", IDX_STATUS, 32'h0, 32'h20);
    apb(1'b0, IDX_CMP_A, 8'h00);
    wr(IDX_CMP_B, 8'h00);
    rchk("cmp cleared", IDX_STATUS, 32'h0, 32'h48);
    wr(IDX_CTRL_A, 8'h08);
    @(negedge pclk);
    chk("force a", 32'h0, {31'h0, pins.out_a});
    wr(IDX_CTRL_B, 8'hC4);
    wr(IDX_CTRL_A, 8'h14);
    @(negedge pclk);
    chk("force b", 32'h3, {30'h0, pins.out_b, pins.oe_b});
    // Each edge choice: the other edge is ignored, the chosen one counts.
    for (int s = 0; s < 2; s++) begin
      wr(IDX_CTRL_A, {6'b100000, s[0], 1'b0});
      wr(IDX_CTRL_B, {6'b000001, s[0], 1'b0});
      for (int c = 0; c < 2; c++) begin
        ci = (c == 0) ? IDX_CAP_A : IDX_CAP_B;
        fb = (c == 0) ? 8'h80 : 8'h10;
        u_pins.set_cap(c, s[0]);
        repeat (6) @(posedge pclk);
        clr(ci);
        u_pins.set_cap(c, !s[0]);
        repeat (6) @(posedge pclk);
        rchk("wrong edge", IDX_STATUS, 32'h0, {24'h0, fb});
        u_pins.set_cap(c, s[0]);
        repeat (6) @(posedge pclk);
        rchk("capture", IDX_STATUS, {24'h0, fb}, {24'h0, fb});
        chk("cap irq", 32'h1, {31'h0, timer_irq});
        clr(ci);
        rchk("cap clear", IDX_STATUS, 32'h0, {24'h0, fb});
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CTRL_B, {4'h0, k[1:0], 2'b00});
      apb(1'b0, IDX_CNT, 8'h00);
      v0 = rdv[7:0];
      repeat (45) @(posedge pclk);
      apb(1'b0, IDX_CNT, 8'h00);
      v1 = rdv[7:0] - v0;
      chk("rate", 32'h1, {31'h0, v1 + 8'h01 >= rate[k]
        && v1 <= rate[k] + 8'h01});
    end
    wr(IDX_CMP_A, 8'h40);
    wr(IDX_CTRL_A, 8'h06);
    wr(IDX_CTRL_B, 8'hA4);
    u_pins.set_cap(0, 1'b0);
    repeat (4) @(posedge pclk);
    u_pins.set_cap(0, 1'b1);
    repeat (8) @(posedge pclk);
    chk("pulse on", 32'h1, {31'h0, pins.out_a});
    rchk("pulse cap", IDX_CAP_A, 32'hFD, 32'hFF);
    repeat (200) @(posedge pclk);
    chk("pulse off", 32'h0, {31'h0, pins.out_a});
    wr(IDX_CMP_A, 8'h10);
    wr(IDX_CMP_B, 8'h20);
    wr(IDX_CTRL_A, 8'h04);
    md = '{8'h94, 8'hB4};
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CTRL_B, md[m]);
      wr(IDX_CNT, 8'h00);
      clr(IDX_CAP_A);
      r0 = rise_a;
      repeat (300) @(posedge pclk);
      chk("pwm pulses", 32'h1, {31'h0, rise_a - r0 >= 3});
      apb(1'b0, IDX_CNT, 8'h00);
      chk("pwm reload", 32'h1, {31'h0, rdv[7:0] <= 8'h20
        || rdv[7:0] >= 8'hFC});
      rchk("pwm flag", IDX_STATUS, 32'h80, 32'h80);
    end
    test_done();
  end
endmodule : eight_bit_timer_control_test
`default_nettype wire
